// >>> design/timer_pkg.sv
// Register map, field layout and clock-select codes of the compact timer
package timer_pkg;
  // Register byte addresses on the APB slave
  localparam logic [7:0] pin_enable_addr = 8'h00;
  localparam logic [7:0] control_zero_addr = 8'h04;
  localparam logic [7:0] control_one_addr = 8'h08;
  localparam logic [7:0] count_low_addr = 8'h0c;
  localparam logic [7:0] count_high_addr = 8'h10;
  localparam logic [7:0] compare_low_addr = 8'h14;
  localparam logic [7:0] compare_high_addr = 8'h18;
  localparam logic [7:0] period_compare_addr = 8'h1c;

  // Pin-enable register fields
  localparam int first_pin_bit = 0;
  localparam int second_pin_bit = 1;
  localparam logic [7:0] pin_enable_mask = 8'h03;

  // Control zero fields
  localparam int pause_bit = 7;
  localparam int select_hi = 6;
  localparam int select_lo = 4;
  localparam int on_bit = 3;
  localparam logic [7:0] control_zero_mask = 8'hf8;

  // Control one fields
  localparam int mode_hi = 7;
  localparam int mode_lo = 6;
  localparam int clear_select_bit = 0;

  // Reset values and the counter full value
  localparam logic [7:0] pin_enable_reset = 8'h00;
  localparam logic [7:0] control_zero_reset = 8'h00;
  localparam logic [7:0] control_one_reset = 8'h00;
  localparam logic [7:0] period_reset = 8'h00;
  localparam logic [15:0] count_reset = 16'h0000;
  localparam logic [15:0] compare_reset = 16'h0000;
  localparam logic [15:0] count_full = 16'hffff;

  // Clock select codes
  localparam logic [2:0] sel_sys_div4 = 3'h0;
  localparam logic [2:0] sel_sys = 3'h1;
  localparam logic [2:0] sel_high_div16 = 3'h2;
  localparam logic [2:0] sel_high_div64 = 3'h3;
  localparam logic [2:0] sel_timebase = 3'h4;
  localparam logic [2:0] sel_high_div8 = 3'h5;
  localparam logic [2:0] sel_pin_rise = 3'h6;
  localparam logic [2:0] sel_pin_fall = 3'h7;

  // Prescaler terminal counts
  localparam logic [1:0] sys_div4_last = 2'h3;
  localparam logic [5:0] high_div8_last = 6'h07;
  localparam logic [5:0] high_div16_last = 6'h0f;
  localparam logic [5:0] high_div64_last = 6'h3f;
endpackage : timer_pkg

// >>> design/compact_timer_core.sv
// Compact 16-bit timer core with APB register access and byte-buffered pairs
`timescale 1ns/1ps

// Functional notes
// - Pin bit 1 enables second timer pin
// - Pin bit 0 enables first timer pin
// - Pin register bits 7..2 read zero
// - Low bytes move only via shared buffer
// - Compare low write fills buffer only
// - Compare high write also loads low from buffer
// - High byte read captures low into buffer
// - Low byte read returns buffer contents
// - 16-bit up-counter on selected clock source
// - Period value compares counter upper byte
// - Compare value compares all counter bits
// - Software only clears counter via on bit
// - Counter clears on overflow or match
// - Three modes: compare, timer, PWM output
// - Counter readable as two zero-reset bytes
// - Compare value readable/writable as two bytes
// - Period value is one read/write register
// - Clock select eight documented encodings
// - Pause freezes counter, resume continues
// - On rising clears counter, falling holds it
module compact_timer_core (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic high_clock_tick,
  input wire logic timebase_tick,
  input wire logic external_clock_pin,
  output logic first_pin_enable,
  output logic second_pin_enable,
  output logic [1:0] operating_mode,
  output logic period_match_irq,
  output logic compare_match_irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  logic [7:0] timer_pin_enable;
  logic [7:0] timer_control_zero;
  logic [7:0] timer_control_one;
  logic [7:0] period_compare;
  logic [15:0] compare_value;
  logic [15:0] count;
  logic [7:0] byte_buffer;
  logic [1:0] sys_prescale;
  logic [5:0] high_prescale;
  logic pin_prev;

  function automatic logic hit(input logic [7:0] addr, input logic [7:0] target);
    hit = (addr == target);
  endfunction : hit

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode

  wire setup_phase = psel && !penable && clk_en;
  wire access_phase = psel && penable && clk_en;
  wire wr = access_phase && pwrite;
  wire rd_setup = setup_phase && !pwrite;
  wire mapped = hit(paddr, timer_pkg::pin_enable_addr) || hit(paddr, timer_pkg::control_zero_addr)
    || hit(paddr, timer_pkg::control_one_addr) || hit(paddr, timer_pkg::count_low_addr)
    || hit(paddr, timer_pkg::count_high_addr) || hit(paddr, timer_pkg::compare_low_addr)
    || hit(paddr, timer_pkg::compare_high_addr) || hit(paddr, timer_pkg::period_compare_addr);
  wire wr_pin = wr && hit(paddr, timer_pkg::pin_enable_addr);
  wire wr_ctl0 = wr && hit(paddr, timer_pkg::control_zero_addr);
  wire wr_ctl1 = wr && hit(paddr, timer_pkg::control_one_addr);
  wire wr_cmp_low = wr && hit(paddr, timer_pkg::compare_low_addr);
  wire wr_cmp_high = wr && hit(paddr, timer_pkg::compare_high_addr);
  wire wr_period = wr && hit(paddr, timer_pkg::period_compare_addr);
  wire rd_count_high = rd_setup && hit(paddr, timer_pkg::count_high_addr);
  wire rd_cmp_high = rd_setup && hit(paddr, timer_pkg::compare_high_addr);

  // Zero wait states; a frozen block stretches the access instead
  assign pready = clk_en;
  assign pslverr = psel && penable && !mapped;

  // read mux
  // Read mux; reserved pin-enable and control zero bits come back as zero, control one reads back as written
  wire [7:0] next_read_byte =
    hit(paddr, timer_pkg::pin_enable_addr) ? (timer_pin_enable & timer_pkg::pin_enable_mask) :
    hit(paddr, timer_pkg::control_zero_addr) ? (timer_control_zero & timer_pkg::control_zero_mask) :
    hit(paddr, timer_pkg::control_one_addr) ? timer_control_one :
    hit(paddr, timer_pkg::count_high_addr) ? count[15:8] :
    hit(paddr, timer_pkg::compare_high_addr) ? compare_value[15:8] :
    hit(paddr, timer_pkg::period_compare_addr) ? period_compare :
    (hit(paddr, timer_pkg::count_low_addr) || hit(paddr, timer_pkg::compare_low_addr)) ? byte_buffer :
    8'h00;

  // Read data is sampled in the setup cycle so high byte and buffer agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (rd_setup) begin
      prdata <= {24'h000000, next_read_byte};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control registers

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_pin_enable <= timer_pkg::pin_enable_reset;
      timer_control_zero <= timer_pkg::control_zero_reset;
      timer_control_one <= timer_pkg::control_one_reset;
      period_compare <= timer_pkg::period_reset;
    end else begin
      if (wr_pin) begin
        timer_pin_enable <= pwdata[7:0] & timer_pkg::pin_enable_mask;
      end
      if (wr_ctl0) begin
        timer_control_zero <= pwdata[7:0] & timer_pkg::control_zero_mask;
      end
      if (wr_ctl1) begin
        timer_control_one <= pwdata[7:0];
      end
      if (wr_period) begin
        period_compare <= pwdata[7:0];
      end
    end
  end

  assign first_pin_enable = timer_pin_enable[timer_pkg::first_pin_bit];
  assign second_pin_enable = timer_pin_enable[timer_pkg::second_pin_bit];
  // mode field steers the output stage outside
  assign operating_mode = timer_control_one[timer_pkg::mode_hi:timer_pkg::mode_lo];

  wire counter_on = timer_control_zero[timer_pkg::on_bit];
  wire counter_pause = timer_control_zero[timer_pkg::pause_bit];
  wire [2:0] clock_select = timer_control_zero[timer_pkg::select_hi:timer_pkg::select_lo];
  wire clear_on_compare = timer_control_one[timer_pkg::clear_select_bit];
  wire turn_on = wr_ctl0 && pwdata[timer_pkg::on_bit] && !counter_on;

  ////////////////////////////////////////////////////////////////////////////
  // Shared low-byte buffer and compare pair

  // buffer moves data only on compare low write or high-byte read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      byte_buffer <= 8'h00;
      compare_value <= timer_pkg::compare_reset;
    end else begin
      if (wr_cmp_low) begin
        byte_buffer <= pwdata[7:0];
      end else if (rd_count_high) begin
        byte_buffer <= count[7:0];
      end else if (rd_cmp_high) begin
        byte_buffer <= compare_value[7:0];
      end
      if (wr_cmp_high) begin
        compare_value <= {pwdata[7:0], byte_buffer};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Clock source selection

  // The pin is synchronous to pclk, so one stage suffices for edges
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sys_prescale <= 2'h0;
      high_prescale <= 6'h00;
      pin_prev <= 1'b0;
    end else if (clk_en) begin
      sys_prescale <= sys_prescale + 2'h1;
      if (high_clock_tick) begin
        high_prescale <= high_prescale + 6'h01;
      end
      pin_prev <= external_clock_pin;
    end
  end

  wire high_div8 = high_clock_tick && (high_prescale[2:0] == timer_pkg::high_div8_last[2:0]);
  wire high_div16 = high_clock_tick && (high_prescale[3:0] == timer_pkg::high_div16_last[3:0]);
  wire high_div64 = high_clock_tick && (high_prescale == timer_pkg::high_div64_last);
  wire source_tick =
    (clock_select == timer_pkg::sel_sys_div4) ? (sys_prescale == timer_pkg::sys_div4_last) :
    (clock_select == timer_pkg::sel_sys) ? 1'b1 :
    (clock_select == timer_pkg::sel_high_div16) ? high_div16 :
    (clock_select == timer_pkg::sel_high_div64) ? high_div64 :
    (clock_select == timer_pkg::sel_timebase) ? timebase_tick :
    (clock_select == timer_pkg::sel_high_div8) ? high_div8 :
    (clock_select == timer_pkg::sel_pin_rise) ? (external_clock_pin && !pin_prev) :
    (!external_clock_pin && pin_prev);

  // pause and off both gate counting
  wire tick = clk_en && counter_on && !counter_pause && source_tick;

  ////////////////////////////////////////////////////////////////////////////
  // Counter and comparators

  wire period_hit = (count[15:8] == period_compare);
  wire compare_hit = (count == compare_value);
  wire overflow = (count == timer_pkg::count_full);
  wire clear_now = overflow || (clear_on_compare ? compare_hit : period_hit);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= timer_pkg::count_reset;
    end else if (turn_on) begin
      count <= timer_pkg::count_reset;
    end else if (tick) begin
      count <= clear_now ? timer_pkg::count_reset : count + 16'h0001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      period_match_irq <= 1'b0;
      compare_match_irq <= 1'b0;
    end else if (clk_en) begin
      period_match_irq <= tick && period_hit;
      compare_match_irq <= tick && compare_hit;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  second_pin_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_pin |=> second_pin_enable == $past(pwdata[1]))
    else $error("second pin enable not updated");

  first_pin_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_pin |=> first_pin_enable == $past(pwdata[0]))
    else $error("first pin enable not updated");

  pin_reserved_a: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && penable && !pwrite && hit(paddr, timer_pkg::pin_enable_addr)) |-> prdata[7:2] == 6'h00)
    else $error("reserved pin bits read non-zero");

  low_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_cmp_low |=> compare_value[7:0] == $past(compare_value[7:0]) && byte_buffer == $past(pwdata[7:0]))
    else $error("compare low write reached live byte");

  high_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_cmp_high |=> compare_value == {$past(pwdata[7:0]), $past(byte_buffer)})
    else $error("compare high write pair wrong");

  high_read_a: assert property (@(posedge pclk) disable iff (!presetn)
    rd_count_high |=> byte_buffer == $past(count[7:0]) && prdata[7:0] == $past(count[15:8]))
    else $error("counter high read did not capture low");

  low_read_a: assert property (@(posedge pclk) disable iff (!presetn)
    rd_setup && hit(paddr, timer_pkg::count_low_addr) |=> prdata[7:0] == $past(byte_buffer))
    else $error("low read not from buffer");

  on_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    turn_on |=> count == 16'h0000)
    else $error("counter not cleared on switch-on");

  pause_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    (counter_pause || !counter_on) && !turn_on |=> $stable(count))
    else $error("counter moved while paused or off");

  wrap_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    tick && overflow |=> count == 16'h0000)
    else $error("counter did not clear on overflow");

  count_step_a: assert property (@(posedge pclk) disable iff (!presetn)
    tick && !clear_now && !turn_on |=> count == $past(count) + 16'h0001)
    else $error("counter did not step");

  period_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(period_match_irq) |-> $past(count[15:8]) == $past(period_compare) && $past(tick))
    else $error("period flag without match");

  compare_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(compare_match_irq) |-> $past(count) == $past(compare_value) && $past(tick))
    else $error("compare flag without match");

  period_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    tick && !clear_on_compare && period_hit |=> count == 16'h0000)
    else $error("counter did not clear on period match");

  compare_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    tick && clear_on_compare && compare_hit |=> count == 16'h0000)
    else $error("counter did not clear on compare match");

  count_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    !turn_on && !tick |=> $stable(count))
    else $error("counter changed without tick or switch-on");

  buffer_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    !wr_cmp_low && !rd_count_high && !rd_cmp_high |=> $stable(byte_buffer))
    else $error("buffer changed without pair access");

  compare_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    !wr_cmp_high |=> $stable(compare_value))
    else $error("compare value changed without high write");

  compare_read_a: assert property (@(posedge pclk) disable iff (!presetn)
    rd_cmp_high |=> byte_buffer == $past(compare_value[7:0]) && prdata[7:0] == $past(compare_value[15:8]))
    else $error("compare high read did not capture low");

  cmp_low_read_a: assert property (@(posedge pclk) disable iff (!presetn)
    rd_setup && hit(paddr, timer_pkg::compare_low_addr) |=> prdata[7:0] == $past(byte_buffer))
    else $error("compare low read not from buffer");

  period_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_period |=> period_compare == $past(pwdata[7:0]))
    else $error("period value not written");

  pin_upper_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_pin |=> (timer_pin_enable & ~timer_pkg::pin_enable_mask) == 8'h00)
    else $error("reserved pin bits stored");

  select_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_ctl0 |=> clock_select == $past(pwdata[timer_pkg::select_hi:timer_pkg::select_lo])
      && (timer_control_zero & ~timer_pkg::control_zero_mask) == 8'h00)
    else $error("clock select not written");

  mode_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_ctl1 |=> operating_mode == $past(pwdata[timer_pkg::mode_hi:timer_pkg::mode_lo]))
    else $error("operating mode not written");

  // A frozen block must not move even while the bus is busy
  enable_freeze_a: assert property (@(posedge pclk) disable iff (!presetn)
    !clk_en |=> $stable(count) && $stable(compare_value) && $stable(byte_buffer)
      && $stable(timer_control_zero) && $stable(prdata) && $stable(period_match_irq))
    else $error("state moved while clock enable low");

endmodule : compact_timer_core

// >>> bench/tb.sv
// Self-checking APB testbench for the compact timer core
`timescale 1ns/1ps
module tb;
  logic pclk, presetn, clk_en, psel, penable, pwrite;
  logic high_clock_tick, timebase_tick, external_clock_pin;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdata;
  logic pready, pslverr, rerr, first_pin_enable, second_pin_enable;
  logic period_match_irq, compare_match_irq;
  logic [1:0] operating_mode;
  logic [15:0] c;
  int errors, total_checks, cycles, pirq, cirq, p0;
  int dv[6] = '{4, 1, 16, 64, 1, 8};

  compact_timer_core u_dut (
    .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .high_clock_tick(high_clock_tick), .timebase_tick(timebase_tick),
    .external_clock_pin(external_clock_pin), .first_pin_enable(first_pin_enable),
    .second_pin_enable(second_pin_enable), .operating_mode(operating_mode),
    .period_match_irq(period_match_irq), .compare_match_irq(compare_match_irq)
  );

  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic finish_test();
    if (errors == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : finish_test

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask : check

  // Request held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // No local limit: a hang ends at the bench timeout
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h0, d});
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    apb(1'b0, a, 32'h0);
    check(rdata, {24'h0, exp});
  endtask : rd_chk

  // high byte first
  // High byte first so the buffer holds the matching low byte
  task automatic rd_count(output logic [15:0] v);
    apb(1'b0, timer_pkg::count_high_addr, 32'h0);
    v[15:8] = rdata[7:0];
    apb(1'b0, timer_pkg::count_low_addr, 32'h0);
    v[7:0] = rdata[7:0];
  endtask : rd_count

  task automatic pulses(input int n);
    repeat (n) begin
      @(posedge pclk);
      external_clock_pin <= 1'b1;
      @(posedge pclk);
      @(posedge pclk);
      external_clock_pin <= 1'b0;
      @(posedge pclk);
    end
  endtask : pulses

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge pclk) begin
    cycles++;
    if (period_match_irq === 1'b1) pirq++;
    if (compare_match_irq === 1'b1) cirq++;
    if (cycles == 30000) begin
      errors++;
      finish_test();
    end
  end

  initial begin
    presetn = 1'b0;
    clk_en = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    high_clock_tick = 1'b0;
    timebase_tick = 1'b0;
    external_clock_pin = 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    for (int a = 0; a < 32; a += 4) rd_chk(8'(a), 8'h00);
    check({28'h0, first_pin_enable, second_pin_enable, operating_mode}, 32'h0);
    wr(timer_pkg::pin_enable_addr, 8'hff);
    rd_chk(timer_pkg::pin_enable_addr, 8'h03);
    check({30'h0, second_pin_enable, first_pin_enable}, 32'h3);
    wr(timer_pkg::pin_enable_addr, 8'h02);
    // Register outputs settle one edge after the access edge
    @(posedge pclk);
    check({30'h0, second_pin_enable, first_pin_enable}, 32'h2);
    wr(timer_pkg::control_zero_addr, 8'hff);
    rd_chk(timer_pkg::control_zero_addr, 8'hf8);
    wr(timer_pkg::control_one_addr, 8'hc0);
    @(posedge pclk);
    check({30'h0, operating_mode}, 32'h3);
    apb(1'b0, 8'h20, 32'h0);
    check({31'h0, rerr}, 32'h1);
    wr(timer_pkg::control_zero_addr, 8'h00);
    wr(timer_pkg::control_one_addr, 8'h01);
    // Byte pair buffering of the compare value
    wr(timer_pkg::compare_low_addr, 8'h34);
    rd_chk(timer_pkg::compare_high_addr, 8'h00);
    rd_chk(timer_pkg::compare_low_addr, 8'h00);
    wr(timer_pkg::compare_low_addr, 8'h34);
    wr(timer_pkg::compare_high_addr, 8'h12);
    rd_chk(timer_pkg::compare_high_addr, 8'h12);
    fork
      rd_chk(timer_pkg::compare_low_addr, 8'h34);
      begin
        // Freeze after the setup edge, stretching the access phase
        repeat (2) @(posedge pclk);
        clk_en <= 1'b0;
        repeat (3) @(posedge pclk);
        clk_en <= 1'b1;
      end
    join
    wr(timer_pkg::period_compare_addr, 8'ha5);
    rd_chk(timer_pkg::period_compare_addr, 8'ha5);
    // Event counting on the external pin
    wr(timer_pkg::control_zero_addr, 8'h68);
    pulses(5);
    rd_count(c);
    check({16'h0, c}, 32'h5);
    wr(timer_pkg::count_low_addr, 8'h55);
    wr(timer_pkg::count_high_addr, 8'h55);
    rd_count(c);
    check({16'h0, c}, 32'h5);
    wr(timer_pkg::control_zero_addr, 8'he8);
    pulses(3);
    rd_count(c);
    check({16'h0, c}, 32'h5);
    wr(timer_pkg::control_zero_addr, 8'h68);
    pulses(2);
    rd_count(c);
    check({16'h0, c}, 32'h7);
    wr(timer_pkg::control_zero_addr, 8'h60);
    pulses(2);
    rd_count(c);
    check({16'h0, c}, 32'h7);
    wr(timer_pkg::control_zero_addr, 8'h68);
    rd_count(c);
    check({16'h0, c}, 32'h0);
    // Compare match clears the count and flags it
    wr(timer_pkg::compare_low_addr, 8'h03);
    wr(timer_pkg::compare_high_addr, 8'h00);
    pulses(10);
    rd_count(c);
    // Match at 3 clears: ten ticks end at 2 after two matches
    check({16'h0, c}, 32'h2);
    check(cirq, 32'h2);
    check({31'h0, pirq == 0}, 32'h1);
    // Period compares only the upper byte
    wr(timer_pkg::control_one_addr, 8'h00);
    wr(timer_pkg::period_compare_addr, 8'h01);
    p0 = pirq;
    pulses(4);
    check({31'h0, pirq == p0}, 32'h1);
    wr(timer_pkg::period_compare_addr, 8'h00);
    pulses(4);
    check({31'h0, pirq > p0}, 32'h1);
    // Every clock source, counted over 256 cycles
    wr(timer_pkg::period_compare_addr, 8'ha5);
    wr(timer_pkg::control_one_addr, 8'h01);
    wr(timer_pkg::compare_low_addr, 8'hff);
    wr(timer_pkg::compare_high_addr, 8'hff);
    high_clock_tick <= 1'b1;
    timebase_tick <= 1'b1;
    for (int s = 0; s < 8; s++) begin
      wr(timer_pkg::control_zero_addr, 8'h00);
      wr(timer_pkg::control_zero_addr, {1'b0, 3'(s), 4'h8});
      pulses(64);
      wr(timer_pkg::control_zero_addr, {1'b1, 3'(s), 4'h8});
      rd_count(c);
      if (s > 5) begin
        check({16'h0, c}, 32'd64);
      end else begin
        check({31'h0, c >= 256 / dv[s] - 1 && c <= 264 / dv[s] + 1}, 32'h1);
      end
    end
    finish_test();
  end
endmodule : tb
